// *** verilog/dulrl_channel.sv ***
// One UART channel: host register decode, banked views and internal loopback.
// Assumes shift engines, FIFOs and interrupt logic sit outside and
// that all host pins are synchronous to clk.
//
// Function
// R01 - Modem control bit 4 enables loopback; other functions keep running.
// R02 - Loopback feeds transmit shift output into receive shift input.
// R03 - Loopback holds transmit, RTS and DTR pins; ignores modem input pins.
// R04 - Automatic RTS/CTS flow control is off during loopback.
// R05 - Far side keeps receive pin high throughout a loopback test.
// R06 - Own register set per channel; chip select picks channel, three lines pick register.
// R07 - Divisor access clear: offset 0 reads receive holding, writes transmit holding.
// R08 - Divisor access set, key absent: offsets 0,1 divisor; 2 fraction if enhanced.
// R09 - Zero divisor with divisor access: offsets 0,1 read revision and device id.
// R10 - Key present: trigger/level, feature control, enhanced function, four flow characters.
// R11 - Offset 7: feature bit 6 picks scratch, or level read and mode-select write.
// R12 - Upper enable, status, queue and modem bits need enhanced bit 4, else zero.
// R13 - Interrupt enable bits: rx data, tx empty, line, modem, sleep, off, RTS, CTS.
// R14 - Offset 2 reads interrupt status, writes queue control; top bits show enabled.
// R15 - Line control: word length, stop, parity enable, even, forced, break, divisor access.
// R16 - Modem control: DTR, RTS, out1, out2, loopback, any-resume, infrared, prescaler.
// R17 - Line status read-only: ready, overrun, parity, framing, break, empties, global error.
// R18 - Modem status: four change flags low, four input levels high.
// R19 - Mode select: count select, reserved, direction invert, hysteresis, error timing, sampling.
// R20 - Word length sets character size and compared flow-character bits.
// R21 - Sleep eligible while sleep enable set and nothing pending.
// R22 - Loopback feeds RTS, DTR, out1, out2 into CTS, DSR, ring, carrier.
`timescale 1ns/1ps

module dulrl_channel #(
  parameter bit CHANNEL_B = 1'b0,
  // Arbitrary identification values
  parameter logic [7:0] REVISION_CODE = 8'h01,
  parameter logic [7:0] DEVICE_ID_CODE = 8'h5C
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire dulrl_pkg::dulrl_bus_type host_bus,
  output logic [7:0] read_data,
  input wire logic [7:0] rx_holding_in,
  input wire logic [7:0] line_status_in,
  input wire logic [5:0] interrupt_status_in,
  input wire logic [7:0] fifo_level_in,
  input wire logic tx_shift_out,
  input wire logic rx_pin,
  input wire dulrl_pkg::dulrl_modem_in_type modem_pins,
  input wire logic [7:0] rx_char,
  input wire logic rx_char_valid,
  output logic rx_shift_in,
  output dulrl_pkg::dulrl_modem_out_type modem_out,
  output dulrl_pkg::dulrl_pulse_type strobes,
  output logic [7:0] write_data,
  output dulrl_pkg::dulrl_cfg_type config_out,
  output logic special_char_hit
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic dulrl_pkg::dulrl_bank_type bank_of(input logic [7:0] line_control);
    if (line_control == dulrl_pkg::ENH_KEY) begin
      return dulrl_pkg::BANK_ENH;
    end else if (line_control[dulrl_pkg::LCR_DIV_BIT]) begin
      return dulrl_pkg::BANK_DIV;
    end
    return dulrl_pkg::BANK_STD;
  endfunction

  function automatic logic [7:0] mask_of(input logic [1:0] wlen);
    unique case (wlen)
      2'd0: return 8'h1F;
      2'd1: return 8'h3F;
      2'd2: return 8'h7F;
      2'd3: return 8'hFF;
    endcase
  endfunction

  dulrl_pkg::dulrl_state_type st_q;
  dulrl_pkg::dulrl_state_type st_d;
  dulrl_pkg::dulrl_bank_type bank;
  logic sel;
  logic wr_fire;
  logic rd_fire;
  logic enh;
  logic loop_q;
  logic div_zero;
  logic [3:0] lvl;
  logic [7:0] w;
  logic [7:0] rv;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.pulse = '0;
    rv = st_q.rdata;
    // R06 own channel select
    sel = CHANNEL_B ? !host_bus.cs_b_n : !host_bus.cs_a_n;
    // Act once per strobe, on its leading edge
    wr_fire = sel && !host_bus.wr_n && st_q.wr_n_prev;
    rd_fire = sel && !host_bus.rd_n && st_q.rd_n_prev;
    st_d.wr_n_prev = !sel || host_bus.wr_n;
    st_d.rd_n_prev = !sel || host_bus.rd_n;
    w = host_bus.wdata;
    bank = bank_of(st_q.cfg.line_control);
    enh = st_q.cfg.enhanced_function[dulrl_pkg::EFR_ENH_BIT];
    loop_q = st_q.cfg.modem_control[dulrl_pkg::MCR_LOOP_BIT];
    div_zero = (st_q.cfg.dll == dulrl_pkg::ZERO_BYTE) && (st_q.cfg.divisor_high == dulrl_pkg::ZERO_BYTE);
    // R22 internal modem feedback
    // R03 input pins ignored
    if (loop_q) begin
      lvl = {st_q.cfg.modem_control[3], st_q.cfg.modem_control[2], st_q.cfg.modem_control[0], st_q.cfg.modem_control[1]};
    end else begin
      lvl = ~{modem_pins.cd_n, modem_pins.ri_n, modem_pins.dsr_n, modem_pins.cts_n};
    end

    // R10 enhanced bank writes
    // R12 gated upper bits
    if (wr_fire) begin
      unique case (host_bus.addr)
        dulrl_pkg::OFS_HOLDING: begin
          if (bank == dulrl_pkg::BANK_ENH) begin
            st_d.cfg.fifo_trigger_level = w;
            st_d.pulse.trg_load = 1'b1;
          end else if (bank == dulrl_pkg::BANK_DIV) begin
            // R08 divisor low
            st_d.cfg.dll = w;
          end else begin
            // R07 transmit holding
            st_d.wdata = w;
            st_d.pulse.tx_load = 1'b1;
          end
        end
        dulrl_pkg::OFS_INT_ENABLE: begin
          if (bank == dulrl_pkg::BANK_ENH) begin
            st_d.cfg.feature_control = w;
          end else if (bank == dulrl_pkg::BANK_DIV) begin
            st_d.cfg.divisor_high = w;
          end else begin
            // R13 enable bits
            st_d.cfg.interrupt_enable = {enh ? w[7:4] : st_q.cfg.interrupt_enable[7:4], w[3:0]};
          end
        end
        dulrl_pkg::OFS_INT_STATUS: begin
          if (bank == dulrl_pkg::BANK_ENH) begin
            st_d.cfg.enhanced_function = w;
          end else if (bank == dulrl_pkg::BANK_DIV && enh) begin
            // R08 fraction needs enhanced
            st_d.cfg.divisor_fraction = w[3:0];
          end else begin
            // R14 queue control write
            st_d.cfg.queue_control = {w[7:6], enh ? w[5:4] : st_q.cfg.queue_control[5:4], w[3], 2'b00, w[0]};
            st_d.pulse.rx_rst = w[dulrl_pkg::FCR_RXRST_BIT];
            st_d.pulse.tx_rst = w[dulrl_pkg::FCR_TXRST_BIT];
          end
        end
        dulrl_pkg::OFS_LINE_CTRL: begin
          // R15 line control
          st_d.cfg.line_control = w;
        end
        dulrl_pkg::OFS_MODEM_CTRL: begin
          if (bank == dulrl_pkg::BANK_ENH) begin
            st_d.xon1 = w;
          end else begin
            // R16 modem control
            // R01 loopback bit
            st_d.cfg.modem_control = {enh ? w[7:5] : st_q.cfg.modem_control[7:5], w[4:0]};
          end
        end
        dulrl_pkg::OFS_LINE_STAT: begin
          if (bank == dulrl_pkg::BANK_ENH) begin
            st_d.xon2 = w;
          end
        end
        dulrl_pkg::OFS_MODEM_STAT: begin
          if (bank == dulrl_pkg::BANK_ENH) begin
            st_d.xoff1 = w;
          end
        end
        dulrl_pkg::OFS_SCRATCH: begin
          if (bank == dulrl_pkg::BANK_ENH) begin
            st_d.xoff2 = w;
          end else if (st_q.cfg.feature_control[dulrl_pkg::FEATURE_CONTROL_SWAP_BIT]) begin
            // R19 mode select write
            st_d.cfg.enhanced_mode_select = w;
          end else begin
            // R11 scratch write
            st_d.scratch_byte = w;
          end
        end
      endcase
    end

    // R06 register read decode
    if (rd_fire) begin
      unique case (host_bus.addr)
        dulrl_pkg::OFS_HOLDING: begin
          if (bank == dulrl_pkg::BANK_ENH) begin
            rv = fifo_level_in;
          end else if (bank == dulrl_pkg::BANK_DIV) begin
            // R09 revision on zero divisor
            rv = div_zero ? REVISION_CODE : st_q.cfg.dll;
          end else begin
            // R07 receive holding
            rv = rx_holding_in;
            st_d.pulse.rx_pop = 1'b1;
          end
        end
        dulrl_pkg::OFS_INT_ENABLE: begin
          if (bank == dulrl_pkg::BANK_ENH) begin
            rv = st_q.cfg.feature_control;
          end else if (bank == dulrl_pkg::BANK_DIV) begin
            rv = div_zero ? DEVICE_ID_CODE : st_q.cfg.divisor_high;
          end else begin
            // R12 upper enables read zero
            rv = {enh ? st_q.cfg.interrupt_enable[7:4] : 4'h0, st_q.cfg.interrupt_enable[3:0]};
          end
        end
        dulrl_pkg::OFS_INT_STATUS: begin
          if (bank == dulrl_pkg::BANK_ENH) begin
            rv = st_q.cfg.enhanced_function;
          end else if (bank == dulrl_pkg::BANK_DIV && enh) begin
            rv = {4'h0, st_q.cfg.divisor_fraction};
          end else begin
            // R14 status with enabled flags
            rv = {{2{st_q.cfg.queue_control[dulrl_pkg::FCR_EN_BIT]}}, enh ? interrupt_status_in[5:4] : 2'b00,
                  interrupt_status_in[3:0]};
          end
        end
        dulrl_pkg::OFS_LINE_CTRL: begin
          rv = st_q.cfg.line_control;
        end
        dulrl_pkg::OFS_MODEM_CTRL: begin
          if (bank == dulrl_pkg::BANK_ENH) begin
            rv = st_q.xon1;
          end else begin
            rv = {enh ? st_q.cfg.modem_control[7:5] : 3'b000, st_q.cfg.modem_control[4:0]};
          end
        end
        dulrl_pkg::OFS_LINE_STAT: begin
          // R17 line status passthrough
          rv = (bank == dulrl_pkg::BANK_ENH) ? st_q.xon2 : line_status_in;
        end
        dulrl_pkg::OFS_MODEM_STAT: begin
          if (bank == dulrl_pkg::BANK_ENH) begin
            rv = st_q.xoff1;
          end else begin
            // R18 levels over change flags
            rv = {lvl, st_q.delta};
            st_d.pulse.msr_read = 1'b1;
          end
        end
        dulrl_pkg::OFS_SCRATCH: begin
          if (bank == dulrl_pkg::BANK_ENH) begin
            rv = st_q.xoff2;
          end else if (st_q.cfg.feature_control[dulrl_pkg::FEATURE_CONTROL_SWAP_BIT]) begin
            // R11 level alias read
            rv = fifo_level_in;
          end else begin
            rv = st_q.scratch_byte;
          end
        end
      endcase
    end
    st_d.rdata = rv;

    // Change flags: a change in the read cycle survives the clear
    st_d.prev = lvl;
    st_d.delta = (st_d.pulse.msr_read ? 4'h0 : st_q.delta) | (lvl ^ st_q.prev);

    // R20 compare width
    st_d.cfg.char_mask = mask_of(st_d.cfg.line_control[1:0]);
    st_d.spec_hit = rx_char_valid && st_q.cfg.enhanced_function[dulrl_pkg::EFR_SPEC_BIT] &&
                    (((rx_char ^ st_q.xoff2) & mask_of(st_q.cfg.line_control[1:0])) == dulrl_pkg::ZERO_BYTE);

    // R01 loopback follows the new value
    st_d.cfg.loopback = st_d.cfg.modem_control[dulrl_pkg::MCR_LOOP_BIT];
    // R04 no auto flow in loopback
    st_d.cfg.auto_cts = st_d.cfg.enhanced_function[dulrl_pkg::EFR_ACTS_BIT] && !st_d.cfg.loopback;
    st_d.cfg.auto_rts = st_d.cfg.enhanced_function[dulrl_pkg::EFR_ARTS_BIT] && !st_d.cfg.loopback;
    // R21 sleep eligibility
    st_d.cfg.sleep_ok = st_q.cfg.interrupt_enable[dulrl_pkg::IER_SLEEP_BIT] &&
                        interrupt_status_in[dulrl_pkg::ISR_NONE_BIT];

    // R03 pins parked at idle levels
    if (st_d.cfg.loopback) begin
      st_d.mout = dulrl_pkg::MOUT_RST;
    end else begin
      st_d.mout.tx = tx_shift_out;
      st_d.mout.dtr_n = !st_d.cfg.modem_control[0];
      st_d.mout.rts_n = !st_d.cfg.modem_control[1];
      st_d.mout.op1_n = !st_d.cfg.modem_control[2];
      st_d.mout.op2_n = !st_d.cfg.modem_control[3];
    end
    // R02 serial loop path
    // R05 pin unused while looped
    st_d.rx_shift = st_d.cfg.loopback ? tx_shift_out : rx_pin;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= dulrl_pkg::ST_RST;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign read_data = st_q.rdata;
  assign rx_shift_in = st_q.rx_shift;
  assign modem_out = st_q.mout;
  assign strobes = st_q.pulse;
  assign write_data = st_q.wdata;
  assign config_out = st_q.cfg;
  assign special_char_hit = st_q.spec_hit;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !clk_en);

  loop_pins_held_a: assert property (st_q.cfg.modem_control[4] |-> modem_out == dulrl_pkg::MOUT_RST) // R03
    else $error("Pins not parked in loopback");

  loop_route_a: assert property (st_q.cfg.loopback && $past(clk_en) |-> rx_shift_in == $past(tx_shift_out)) // R02
    else $error("Loopback serial path broken");

  loop_no_auto_a: assert property (st_q.cfg.loopback |-> !config_out.auto_cts && !config_out.auto_rts) // R04
    else $error("Auto flow active in loopback");

  tx_hold_write_a: assert property (wr_fire && bank == dulrl_pkg::BANK_STD && host_bus.addr == 3'h0 // R07
                                    |=> strobes.tx_load && write_data == $past(host_bus.wdata))
    else $error("Transmit holding write lost");

  div_low_read_a: assert property (rd_fire && bank == dulrl_pkg::BANK_DIV && !div_zero // R08
                                   && host_bus.addr == 3'h0 |=> read_data == $past(st_q.cfg.dll))
    else $error("Divisor low read wrong");

  dev_id_read_a: assert property (rd_fire && bank == dulrl_pkg::BANK_DIV && div_zero // R09
                                  && host_bus.addr == 3'h1 |=> read_data == DEVICE_ID_CODE)
    else $error("Device id not returned");

  ier_upper_gate_a: assert property (rd_fire && !enh && bank == dulrl_pkg::BANK_STD // R12
                                     && host_bus.addr == 3'h1 |=> read_data[7:4] == 4'h0)
    else $error("Upper enable bits visible");

  level_alias_a: assert property (rd_fire && bank != dulrl_pkg::BANK_ENH && st_q.cfg.feature_control[6] // R11
                                  && host_bus.addr == 3'h7 |=> read_data == $past(fifo_level_in))
    else $error("Level alias read wrong");

  msr_loop_levels_a: assert property (rd_fire && loop_q && bank != dulrl_pkg::BANK_ENH // R22
                                      && host_bus.addr == 3'h6 |=> read_data[7:4] ==
                                      {$past(st_q.cfg.modem_control[3]), $past(st_q.cfg.modem_control[2]),
                                       $past(st_q.cfg.modem_control[0]), $past(st_q.cfg.modem_control[1])})
    else $error("Loopback modem levels wrong");

  sleep_ok_a: assert property (st_q.cfg.interrupt_enable[4] && interrupt_status_in[0] |=> config_out.sleep_ok) // R21
    else $error("Sleep eligibility missed");

  loop_enter_c: cover property (!st_q.cfg.loopback ##1 st_q.cfg.loopback);
  dev_id_c: cover property (rd_fire && bank == dulrl_pkg::BANK_DIV && div_zero);
  enh_write_c: cover property (wr_fire && bank == dulrl_pkg::BANK_ENH);
  loop_msr_c: cover property (rd_fire && loop_q && host_bus.addr == 3'h6);

  // Queue resets are pulses only; the bits are never stored
  fifo_reset_pulse_a: assert property (wr_fire && bank == dulrl_pkg::BANK_STD && host_bus.addr == 3'h2 // R14
                                       |=> strobes.rx_rst == $past(host_bus.wdata[1]))
    else $error("Queue reset pulse wrong");

endmodule

// *** verilog/dulrl_pkg.sv ***
// Package for the UART channel register decode and loopback block.
// Assumes one 125 MHz clock and a synchronously sampled host bus.
package dulrl_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [2:0] OFS_HOLDING = 3'h0;
  localparam logic [2:0] OFS_INT_ENABLE = 3'h1;
  localparam logic [2:0] OFS_INT_STATUS = 3'h2;
  localparam logic [2:0] OFS_LINE_CTRL = 3'h3;
  localparam logic [2:0] OFS_MODEM_CTRL = 3'h4;
  localparam logic [2:0] OFS_LINE_STAT = 3'h5;
  localparam logic [2:0] OFS_MODEM_STAT = 3'h6;
  localparam logic [2:0] OFS_SCRATCH = 3'h7;

  // ----------------------------------------
  // Field positions and values
  // ----------------------------------------
  localparam logic [7:0] ENH_KEY = 8'hBF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int LCR_DIV_BIT = 7;
  localparam int MCR_LOOP_BIT = 4;
  localparam int EFR_ENH_BIT = 4;
  localparam int EFR_SPEC_BIT = 5;
  localparam int EFR_ARTS_BIT = 6;
  localparam int EFR_ACTS_BIT = 7;
  localparam int FEATURE_CONTROL_SWAP_BIT = 6;
  localparam int IER_SLEEP_BIT = 4;
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_RXRST_BIT = 1;
  localparam int FCR_TXRST_BIT = 2;
  localparam int ISR_NONE_BIT = 0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {BANK_STD, BANK_DIV, BANK_ENH} dulrl_bank_type;

  typedef struct packed {
    logic cs_a_n;
    logic cs_b_n;
    logic [2:0] addr;
    logic rd_n;
    logic wr_n;
    logic [7:0] wdata;
  } dulrl_bus_type;

  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic ri_n;
    logic cd_n;
  } dulrl_modem_in_type;

  typedef struct packed {
    logic tx;
    logic rts_n;
    logic dtr_n;
    logic op1_n;
    logic op2_n;
  } dulrl_modem_out_type;

  typedef struct packed {
    logic tx_load;
    logic rx_pop;
    logic rx_rst;
    logic tx_rst;
    logic trg_load;
    logic msr_read;
  } dulrl_pulse_type;

  typedef struct packed {
    logic [7:0] line_control;
    logic [7:0] interrupt_enable;
    logic [7:0] modem_control;
    logic [7:0] queue_control;
    logic [7:0] dll;
    logic [7:0] divisor_high;
    logic [3:0] divisor_fraction;
    logic [7:0] feature_control;
    logic [7:0] enhanced_function;
    logic [7:0] enhanced_mode_select;
    logic [7:0] fifo_trigger_level;
    logic [7:0] char_mask;
    logic loopback;
    logic auto_cts;
    logic auto_rts;
    logic sleep_ok;
  } dulrl_cfg_type;

  typedef struct packed {
    dulrl_cfg_type cfg;
    logic [7:0] scratch_byte;
    logic [7:0] xon1;
    logic [7:0] xon2;
    logic [7:0] xoff1;
    logic [7:0] xoff2;
    logic [3:0] delta;
    logic [3:0] prev;
    dulrl_pulse_type pulse;
    logic [7:0] wdata;
    logic [7:0] rdata;
    dulrl_modem_out_type mout;
    logic rx_shift;
    logic spec_hit;
    logic rd_n_prev;
    logic wr_n_prev;
  } dulrl_state_type;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam dulrl_cfg_type CFG_RST = '{char_mask: 8'h1F, default: '0};
  localparam dulrl_modem_out_type MOUT_RST = '{default: 1'b1};
  localparam dulrl_state_type ST_RST = '{cfg: CFG_RST, mout: MOUT_RST, rx_shift: 1'b1,
                                        rd_n_prev: 1'b1, wr_n_prev: 1'b1, default: '0};

endpackage

// *** verif/dulrl_line_partner.sv ***
// Line-side partner for one UART channel: shift output, receive pin, modem pins.
// Assumes the bench drives the modem pin levels and shares one clock.
`timescale 1ns/1ps

module dulrl_line_partner (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] pin_levels,
  output logic tx_shift_out,
  output logic rx_pin,
  output dulrl_pkg::dulrl_modem_in_type modem_pins
);
  // ----------------------------------------
  // Transmit shift stand-in
  // ----------------------------------------
  logic [2:0] cnt_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // Pattern keeps changing so a stuck loop path shows up
  assign tx_shift_out = cnt_q[0] ^ cnt_q[2];

  // ----------------------------------------
  // Line and modem pins
  // ----------------------------------------
  // receive pin marks
  assign rx_pin = 1'b1;
  assign modem_pins = pin_levels;
endmodule

// *** verif/dulrl_bench.sv ***
// Self-checking bench for two channel register decoders sharing one host bus.
// Assumes the design package is compiled first and the partner model beside it.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end

module dulrl_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  // Identification values are arbitrary
  localparam logic [7:0] REV = 8'h21;
  localparam logic [7:0] DID = 8'h47;
  localparam dulrl_pkg::dulrl_bus_type BUS_IDLE = '{cs_a_n: 1'b1, cs_b_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
  int n_errors = 0;
  int n_compared = 0;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  dulrl_pkg::dulrl_bus_type bus = BUS_IDLE;
  logic [7:0] rx_hold = 8'h00;
  logic [7:0] ls_in = 8'h00;
  logic [7:0] lvl_in = 8'h00;
  logic [7:0] rx_char = 8'h00;
  logic [5:0] isr_in = 6'h01;
  logic rx_char_valid = 1'b0;
  logic [3:0] pin_levels = 4'hF;
  logic tx_w;
  logic rxp_w;
  dulrl_pkg::dulrl_modem_in_type mp_w;
  logic [7:0] rdat [2];
  logic [7:0] wdat [2];
  logic rsi [2];
  logic hit [2];
  dulrl_pkg::dulrl_modem_out_type mo [2];
  dulrl_pkg::dulrl_pulse_type stb [2];
  dulrl_pkg::dulrl_cfg_type cfg [2];
  logic [7:0] rd;
  dulrl_pkg::dulrl_pulse_type st;
  logic prev_tx;

  always #4 clk = ~clk;

  dulrl_line_partner dulrl_line_partner_inst (.clk(clk), .srst(srst), .pin_levels(pin_levels),
    .tx_shift_out(tx_w), .rx_pin(rxp_w), .modem_pins(mp_w));

  for (genvar g = 0; g < 2; g++) begin : chan
    dulrl_channel #(.CHANNEL_B(g == 1), .REVISION_CODE(REV), .DEVICE_ID_CODE(DID)) dulrl_channel_inst (
      .clk(clk), .srst(srst), .clk_en(clk_en), .host_bus(bus), .read_data(rdat[g]),
      .rx_holding_in(rx_hold), .line_status_in(ls_in), .interrupt_status_in(isr_in),
      .fifo_level_in(lvl_in), .tx_shift_out(tx_w), .rx_pin(rxp_w), .modem_pins(mp_w),
      .rx_char(rx_char), .rx_char_valid(rx_char_valid), .rx_shift_in(rsi[g]), .modem_out(mo[g]),
      .strobes(stb[g]), .write_data(wdat[g]), .config_out(cfg[g]), .special_char_hit(hit[g]));
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic acc(input int c, input bit w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.cs_a_n <= (c != 0);
    bus.cs_b_n <= (c == 0);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr_n <= !w;
    bus.rd_n <= w;
    @(posedge clk);
    bus <= BUS_IDLE;
    #1;
    rd = rdat[c];
    st = stb[c];
  endtask

  task automatic wr(input int c, input logic [2:0] a, input logic [7:0] d);
    acc(c, 1'b1, a, d);
  endtask

  task automatic rdc(input int c, input logic [2:0] a, input logic [7:0] e);
    acc(c, 1'b0, a, 8'h00);
    `CHK(rd, e)
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rdc(0, 3'h3, 8'h00);
    `CHK(mo[0], 5'h1F)
    `CHK(cfg[0].char_mask, 8'h1F)
    $display("end of test reset");
    wr(0, 3'h7, 8'h5A);
    wr(1, 3'h7, 8'hA5);
    rdc(0, 3'h7, 8'h5A);
    rdc(1, 3'h7, 8'hA5);
    clk_en <= 1'b0;
    wr(0, 3'h7, 8'h77);
    clk_en <= 1'b1;
    rdc(0, 3'h7, 8'h5A);
    $display("end of test channels");
    rx_hold <= 8'h6E;
    ls_in <= 8'h61;
    rdc(0, 3'h0, 8'h6E);
    `CHK(st.rx_pop, 1'b1)
    wr(0, 3'h0, 8'hC3);
    `CHK(st.tx_load, 1'b1)
    `CHK(wdat[0], 8'hC3)
    rdc(0, 3'h5, 8'h61);
    $display("end of test holding");
    isr_in <= 6'h31;
    wr(0, 3'h3, 8'h80);
    rdc(0, 3'h0, REV);
    rdc(0, 3'h1, DID);
    wr(0, 3'h0, 8'h12);
    wr(0, 3'h1, 8'h34);
    rdc(0, 3'h0, 8'h12);
    rdc(0, 3'h1, 8'h34);
    rdc(0, 3'h2, 8'h01);
    $display("end of test divisor");
    wr(0, 3'h3, 8'h03);
    `CHK(cfg[0].char_mask, 8'hFF)
    wr(0, 3'h1, 8'hFF);
    rdc(0, 3'h1, 8'h0F);
    wr(0, 3'h4, 8'hE0);
    rdc(0, 3'h4, 8'h00);
    wr(0, 3'h2, 8'h01);
    rdc(0, 3'h2, 8'hC1);
    wr(0, 3'h2, 8'h07);
    `CHK({st.rx_rst, st.tx_rst}, 2'b11)
    $display("end of test gating");
    wr(0, 3'h3, 8'hBF);
    wr(0, 3'h2, 8'hF0);
    rdc(0, 3'h2, 8'hF0);
    wr(0, 3'h1, 8'h40);
    rdc(0, 3'h1, 8'h40);
    for (int k = 4; k < 8; k++) wr(0, 3'(k), 8'h10 + 8'(k));
    for (int k = 4; k < 8; k++) rdc(0, 3'(k), 8'h10 + 8'(k));
    lvl_in <= 8'h2A;
    rdc(0, 3'h0, 8'h2A);
    wr(0, 3'h0, 8'h55);
    `CHK(cfg[0].fifo_trigger_level, 8'h55)
    `CHK(st.trg_load, 1'b1)
    $display("end of test enhanced");
    wr(0, 3'h3, 8'h03);
    wr(0, 3'h1, 8'hFF);
    rdc(0, 3'h1, 8'hFF);
    rdc(0, 3'h2, 8'hF1);
    tick(1);
    `CHK(cfg[0].sleep_ok, 1'b1)
    wr(0, 3'h1, 8'h0F);
    tick(1);
    `CHK(cfg[0].sleep_ok, 1'b0)
    rdc(0, 3'h7, 8'h2A);
    wr(0, 3'h7, 8'h9C);
    `CHK(cfg[0].enhanced_mode_select, 8'h9C)
    wr(0, 3'h3, 8'h80);
    wr(0, 3'h2, 8'h07);
    rdc(0, 3'h2, 8'h07);
    `CHK(cfg[0].auto_cts, 1'b1)
    $display("end of test unlocked");
    wr(0, 3'h3, 8'h03);
    rdc(0, 3'h6, 8'h00);
    wr(0, 3'h4, 8'h1B);
    `CHK(mo[0], 5'h1F)
    `CHK(cfg[0].loopback, 1'b1)
    `CHK({cfg[0].auto_cts, cfg[0].auto_rts}, 2'b00)
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      prev_tx = tx_w;
      #1;
      `CHK(rsi[0], prev_tx)
    end
    rdc(0, 3'h6, 8'hBB);
    `CHK(st.msr_read, 1'b1)
    pin_levels <= 4'h0;
    tick(2);
    rdc(0, 3'h6, 8'hB0);
    wr(0, 3'h0, 8'h44);
    `CHK(st.tx_load, 1'b1)
    wr(0, 3'h3, 8'h00);
    `CHK(cfg[0].char_mask, 8'h1F)
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      rx_char <= 8'hF7 - 8'(k);
      rx_char_valid <= 1'b1;
      @(posedge clk);
      rx_char_valid <= 1'b0;
      #1;
      `CHK(hit[0], (k == 0))
    end
    wr(0, 3'h4, 8'h03);
    `CHK({mo[0].rts_n, mo[0].dtr_n, rsi[0]}, 3'b001)
    `CHK(mo[1].rts_n, 1'b1)
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      prev_tx = tx_w;
      #1;
      `CHK(mo[0].tx, prev_tx)
    end
    $display("end of test loopback");
    // Second reset in mid-run
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rdc(0, 3'h7, 8'h00);
    `CHK(mo[0], 5'h1F)
    $display("end of test rerun reset");
    tally_and_finish();
  end

  initial begin
    #20000;
    n_errors++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule
